// file: inc/fdpin_consts.vh
`ifndef FDPIN_CONSTS_VH
`define FDPIN_CONSTS_VH

// Register addresses on the 3-bit host port
`define FDPIN_ADDR_W          3
`define FDPIN_A_INT_STATUS    3'h1
`define FDPIN_A_DRIVE_CTRL    3'h2
`define FDPIN_A_MODE          3'h3
`define FDPIN_A_INT_MASK      3'h4
`define FDPIN_A_TRACK_COUNT   3'h5
`define FDPIN_A_PIN_STATE     3'h6
`define FDPIN_A_MEDIA_RATE    3'h7

// Drive control fields
`define FDPIN_DC_UNIT_LO      0
`define FDPIN_DC_UNIT_HI      1
`define FDPIN_DC_HOST_IRQ_EN  3
`define FDPIN_DC_SPINDLE_LO   4
`define FDPIN_DC_SPINDLE_HI   7
`define FDPIN_DC_RESET        8'h00

// Mode fields
`define FDPIN_MODE_READ_GATE  0
`define FDPIN_MODE_HEAD_ONE   1
`define FDPIN_MODE_RESET      8'h00

// Media change readback bit
`define FDPIN_MEDIA_BIT       7

// Data rate codes
`define FDPIN_RATE_500K       2'h0
`define FDPIN_RATE_300K       2'h1
`define FDPIN_RATE_250K       2'h2
`define FDPIN_RATE_1M         2'h3
`define FDPIN_RATE_RESET      2'h2

// Interrupt status bits
`define FDPIN_EV_ATTENTION    0
`define FDPIN_EV_TRACK_START  1
`define FDPIN_EV_MEDIA_CHANGE 2
`define FDPIN_EV_W            3
`define FDPIN_EV_RESET        3'h0

`endif

// file: rtl/fdpin_sync.v
`timescale 1ns/1ns
module fdpin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] reset_value,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage_one;

// First stage feeds only the second stage
always @(posedge clk_sys) begin
    if (reset) begin
        stage_one <= reset_value;
        sync_out  <= reset_value;
    end else begin
        stage_one <= async_in;
        sync_out  <= stage_one;
    end
end

endmodule

// file: rtl/fdpin_top.v
// Function
// R01: Low two control bits pick drive number
// R02: Select asserted only with matching motor bit
// R03: Four active-low selects, selected one low
// R04: Latched media change read inverted on bit7
// R05: Read-gate mode repurposes media change pin
// R06: Read gate low tracks crystal, high data
// R07: Head output low for head one
// R08: Drive pulses track start low per track
// R09: Interrupt raised when operation needs attention
// R10: Interrupt gated by control bit three
// R11: Low-rate filter grounded at 250/300 kb/s
// R12: High-rate filter grounded at 500 kb/s
// R13: Active-low spindle output per motor bit
// R14: Reset clears drive control to zero
// R15: Drive outputs pull low only when active
// R16: Exactly one filter ground follows rate
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "fdpin_consts.vh"
module fdpin_top #(
    parameter UNITS = 4,
    parameter TRACK_COUNT_W = 8
) (
    input  wire                       clk_sys,
    input  wire                       reset,
    input  wire [`FDPIN_ADDR_W-1:0]   reg_addr,
    input  wire [7:0]                 reg_wdata,
    input  wire                       reg_wr,
    input  wire                       reg_rd,
    output reg  [7:0]                 reg_rdata,
    input  wire                       media_change_input,
    input  wire                       track_start_n,
    input  wire                       op_attention,
    input  wire                       read_active,
    output wire                       unit0_select_n,
    output wire                       unit1_select_n,
    output wire                       unit2_select_n,
    output wire                       unit3_select_n,
    output wire                       unit0_spindle_on_n,
    output wire                       unit1_spindle_on_n,
    output wire                       unit2_spindle_on_n,
    output wire                       unit3_spindle_on_n,
    output reg                        head_choice_output,
    output reg                        low_rate_filter_ground,
    output reg                        high_rate_filter_ground,
    output reg                        sep_lock_to_data,
    output reg  [1:0]                 rate_select,
    output reg                        host_irq
);

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

function [UNITS-1:0] unit_decode;
    input [1:0] unit;
    integer k;
    begin
        unit_decode = {UNITS{1'b0}};
        for (k = 0; k < UNITS; k = k + 1) begin
            if (unit == k[1:0]) begin
                unit_decode[k] = 1'b1;
            end
        end
    end
endfunction

function is_low_rate;
    input [1:0] rate;
    begin
        // Fastest rate joins the high-rate group
        is_low_rate = (rate == `FDPIN_RATE_250K) ||
                      (rate == `FDPIN_RATE_300K);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

wire [1:0] pins_sync;
wire       media_pin;
wire       track_pin_n;

// Both pins idle high, so the chain resets to ones
fdpin_sync #(
    .WIDTH       (2)
) u_pin_sync (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .async_in    ({track_start_n, media_change_input}),
    .reset_value (2'h3),
    .sync_out    (pins_sync)
);

assign media_pin   = pins_sync[0];
assign track_pin_n = pins_sync[1];

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [7:0]               drive_ctrl;
reg  [7:0]               mode_reg;
reg  [`FDPIN_EV_W-1:0]   int_status;
reg  [`FDPIN_EV_W-1:0]   int_mask;
reg  [TRACK_COUNT_W-1:0] track_count;
reg                      media_latch;
reg                      track_prev_n;
reg  [UNITS-1:0]         select_n_q;
reg  [UNITS-1:0]         spindle_n_q;

wire                     read_gate_mode_bit;
wire                     host_signal_enable_bit;
wire [1:0]               unit_num;
wire [UNITS-1:0]         spindle_bits;
wire [UNITS-1:0]         unit_onehot;
wire                     track_start_edge;
wire                     media_change_edge;
wire [`FDPIN_EV_W-1:0]   events;
wire [`FDPIN_EV_W-1:0]   clear_bits;

assign read_gate_mode_bit     = mode_reg[`FDPIN_MODE_READ_GATE];
assign host_signal_enable_bit = drive_ctrl[`FDPIN_DC_HOST_IRQ_EN];
assign unit_num = drive_ctrl[`FDPIN_DC_UNIT_HI:`FDPIN_DC_UNIT_LO]; // [R01]
assign spindle_bits =
    drive_ctrl[`FDPIN_DC_SPINDLE_HI:`FDPIN_DC_SPINDLE_LO];
assign unit_onehot = unit_decode(unit_num);

// Start of track is the low level; count its leading edge once
assign track_start_edge = track_prev_n & ~track_pin_n;           // [R08]

// Media status only follows the pin outside read-gate mode
assign media_change_edge = ~read_gate_mode_bit &
                           (media_pin != media_latch);            // [R05]

assign events = {media_change_edge, track_start_edge, op_attention}; // [R09]

// Write-one-to-clear strobe for the status bits
assign clear_bits = (reg_wr && reg_addr == `FDPIN_A_INT_STATUS) ?
                    reg_wdata[`FDPIN_EV_W-1:0] : {`FDPIN_EV_W{1'b0}};

always @(posedge clk_sys) begin
    if (reset) begin
        drive_ctrl <= `FDPIN_DC_RESET;                            // [R14]
        mode_reg   <= `FDPIN_MODE_RESET;
        int_mask   <= `FDPIN_EV_RESET;
        rate_select <= `FDPIN_RATE_RESET;
    end else if (reg_wr) begin
        case (reg_addr)
            `FDPIN_A_DRIVE_CTRL: begin
                drive_ctrl <= reg_wdata;
            end
            `FDPIN_A_MODE: begin
                mode_reg <= reg_wdata;
            end
            `FDPIN_A_INT_MASK: begin
                int_mask <= reg_wdata[`FDPIN_EV_W-1:0];
            end
            `FDPIN_A_MEDIA_RATE: begin
                rate_select <= reg_wdata[1:0];
            end
            default: begin
                drive_ctrl <= drive_ctrl;
            end
        endcase
    end
end

// Sticky status; a new event wins over a clear in the same cycle
always @(posedge clk_sys) begin
    if (reset) begin
        int_status <= `FDPIN_EV_RESET;
    end else begin
        int_status <= (int_status & ~clear_bits) | events;
    end
end

always @(posedge clk_sys) begin
    if (reset) begin
        media_latch  <= 1'b1;
        track_prev_n <= 1'b1;
        track_count  <= {TRACK_COUNT_W{1'b0}};
    end else begin
        track_prev_n <= track_pin_n;
        // Frozen in read-gate mode; the pin then steers the separator
        if (!read_gate_mode_bit) begin
            media_latch <= media_pin;                             // [R04]
        end
        if (track_start_edge) begin
            track_count <= track_count + 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Drive interface outputs

genvar u;
generate
    for (u = 0; u < UNITS; u = u + 1) begin : g_unit
        wire unit_hit;
        // Select needs both the decoded unit and its own motor bit
        assign unit_hit = unit_onehot[u];
        always @(posedge clk_sys) begin
            if (reset) begin
                select_n_q[u]  <= 1'b1;                           // [R15]
                spindle_n_q[u] <= 1'b1;
            end else begin
                select_n_q[u]  <= ~(unit_hit & spindle_bits[u]);  // [R02] [R03]
                spindle_n_q[u] <= ~spindle_bits[u];               // [R13]
            end
        end
    end
endgenerate

assign unit0_select_n     = select_n_q[0];
assign unit1_select_n     = select_n_q[1];
assign unit2_select_n     = select_n_q[2];
assign unit3_select_n     = select_n_q[3];
assign unit0_spindle_on_n = spindle_n_q[0];
assign unit1_spindle_on_n = spindle_n_q[1];
assign unit2_spindle_on_n = spindle_n_q[2];
assign unit3_spindle_on_n = spindle_n_q[3];

always @(posedge clk_sys) begin
    if (reset) begin
        head_choice_output      <= 1'b1;                          // [R15]
        low_rate_filter_ground  <= 1'b1;
        high_rate_filter_ground <= 1'b0;
        sep_lock_to_data        <= 1'b0;
    end else begin
        // Low pulls the line for head one, released means head zero
        head_choice_output <= ~mode_reg[`FDPIN_MODE_HEAD_ONE];    // [R07]
        low_rate_filter_ground  <= is_low_rate(rate_select);      // [R11] [R16]
        high_rate_filter_ground <= ~is_low_rate(rate_select);     // [R12] [R16]
        if (read_gate_mode_bit) begin
            sep_lock_to_data <= media_pin;                        // [R06]
        end else begin
            sep_lock_to_data <= read_active;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt output

always @(posedge clk_sys) begin
    if (reset) begin
        host_irq <= 1'b0;
    end else begin
        // Level output; drops one clock after enable or mask clears
        host_irq <= host_signal_enable_bit &                      // [R10]
                    (|(int_status & int_mask));                   // [R09]
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, valid the cycle after the read strobe

reg [7:0] next_rdata;

always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
        `FDPIN_A_INT_STATUS: begin
            next_rdata[`FDPIN_EV_W-1:0] = int_status;
        end
        `FDPIN_A_DRIVE_CTRL: begin
            next_rdata = drive_ctrl;
        end
        `FDPIN_A_MODE: begin
            next_rdata = mode_reg;
        end
        `FDPIN_A_INT_MASK: begin
            next_rdata[`FDPIN_EV_W-1:0] = int_mask;
        end
        `FDPIN_A_TRACK_COUNT: begin
            next_rdata = track_count;
        end
        `FDPIN_A_PIN_STATE: begin
            // Synced pin levels plus separator and interrupt outputs for diagnostics
            next_rdata = {4'h0, host_irq, sep_lock_to_data,
                          track_pin_n, media_pin};
        end
        `FDPIN_A_MEDIA_RATE: begin
            next_rdata[`FDPIN_MEDIA_BIT] = ~media_latch;          // [R04]
        end
        default: begin
            next_rdata = 8'h00;
        end
    endcase
end

always @(posedge clk_sys) begin
    if (reset) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        // Zero outside the answer cycle so stale data never lingers
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= 8'h00;
    end
end

endmodule

// file: dv/fdpin_drive.sv
`timescale 1ns/1ns
module fdpin_drive (
    output logic media_change_input,
    output logic track_start_n
);
    // Door shut and no index mark until the bench asks
    initial begin
        media_change_input = 1'b1;
        track_start_n = 1'b1;
    end

    // Pin moves land away from the sampling edge
    task door(input logic v);
        #7 media_change_input = v;
    endtask

    task index_mark;
        #7 track_start_n = 1'b0;
        #100 track_start_n = 1'b1;
    endtask
endmodule

// file: dv/fdpin_chk.sv
`timescale 1ns/1ns
module fdpin_chk (
    input logic       clk_sys,
    input logic       reset,
    input logic [2:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    input logic       unit0_select_n,
    input logic       unit1_select_n,
    input logic       unit2_select_n,
    input logic       unit3_select_n,
    input logic       unit0_spindle_on_n,
    input logic       unit1_spindle_on_n,
    input logic       unit2_spindle_on_n,
    input logic       unit3_spindle_on_n,
    input logic       head_choice_output,
    input logic       low_rate_filter_ground,
    input logic       high_rate_filter_ground,
    input logic [1:0] rate_select,
    input logic       host_irq
);
    logic [7:0] ctrl;
    logic [7:0] mode;
    wire  [3:0] sel_n;
    wire  [3:0] want_n;
    wire        rd7;

    assign sel_n = {unit3_select_n, unit2_select_n, unit1_select_n,
        unit0_select_n};
    assign want_n = ~((4'h1 << ctrl[1:0]) & ctrl[7:4]);
    assign rd7 = reg_rd && reg_addr == 3'h7;

    // Shadow of the writable control state
    always @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= 8'h00;
            mode <= 8'h00;
        end else if (reg_wr && reg_addr == 3'h2) begin
            ctrl <= reg_wdata;
        end else if (reg_wr && reg_addr == 3'h3) begin
            mode <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_SEL: assert property (sel_n == $past(want_n))
        else $error("select not decode and motor");
    AST_ONE: assert property ($onehot0(~sel_n))
        else $error("more than one select low");
    AST_RST: assert property ($past(reset) |-> sel_n == 4'hf)
        else $error("select low after reset");
    AST_HEAD: assert property ($stable(mode[1]) |->
        head_choice_output == !mode[1]) else $error("head level wrong");
    AST_RATE: assert property ($stable(rate_select) |->
        low_rate_filter_ground == (rate_select inside {2'h1, 2'h2}))
        else $error("low rate ground wrong");
    AST_FILT: assert property (low_rate_filter_ground !=
        high_rate_filter_ground) else $error("filter grounds clash");
    AST_IRQ_OFF: assert property (!$past(ctrl[3]) |-> !host_irq)
        else $error("interrupt while disabled");
    AST_MEDIA: assert property ($past(rd7) |->
        reg_rdata[6:0] == 7'h00) else $error("media read low bits set");
    AST_SPIN: assert property ({unit3_spindle_on_n,
        unit2_spindle_on_n, unit1_spindle_on_n, unit0_spindle_on_n} ==
        ~$past(ctrl[7:4])) else $error("spindle not motor bits");
endmodule

bind fdpin_top fdpin_chk chk (.*);

// file: dv/floppy_drive_select_status_pins_bench.sv
`timescale 1ns/1ns
module floppy_drive_select_status_pins_bench;
    logic       clk_sys = 1'b0;
    logic       reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       op_attention = 1'b0;
    logic       read_active = 1'b0;
    logic       f;
    wire  [7:0] reg_rdata;
    wire  [1:0] rate_select;
    wire        media_change_input, track_start_n, host_irq;
    wire        head_choice_output, sep_lock_to_data;
    wire        low_rate_filter_ground, high_rate_filter_ground;
    wire        unit0_select_n, unit1_select_n, unit2_select_n;
    wire        unit3_select_n, unit0_spindle_on_n, unit1_spindle_on_n;
    wire        unit2_spindle_on_n, unit3_spindle_on_n;
    wire  [7:0] pins;
    wire  [7:0] st;
    int         bad_count = 0;
    int         compares = 0;

    assign pins = {unit3_spindle_on_n, unit2_spindle_on_n,
        unit1_spindle_on_n, unit0_spindle_on_n, unit3_select_n,
        unit2_select_n, unit1_select_n, unit0_select_n};
    assign st = {host_irq, sep_lock_to_data, head_choice_output, 1'b0,
        low_rate_filter_ground, high_rate_filter_ground, rate_select};
    always #10 clk_sys = ~clk_sys;
    fdpin_top dut (.*);
    fdpin_drive pin (.*);

    ////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask

    // Returns once the outputs behind the register have settled
    task wr(input logic [2:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(2);
    endtask

    task rd(input logic [2:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
        chk("rdata", e, reg_rdata);
    endtask

    task finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        tick(16);
        reset <= 1'b0;
        tick(1);
        chk("pins", 8'hff, pins);
        chk("st", 8'h2a, st);
        rd(3'h2, 8'h00);
        for (int n = 0; n < 4; n++) begin
            wr(3'h2, (8'hf0 ^ (8'h10 << n)) | n[7:0]);
            chk("pins", 8'h0f | (8'h10 << n), pins);
            wr(3'h2, 8'hf0 | n[7:0]);
            chk("pins", 8'h0f ^ (8'h01 << n), pins);
            rd(3'h2, 8'hf0 | n[7:0]);
        end
        for (int r = 0; r < 4; r++) begin
            f = (r == 1 || r == 2);
            wr(3'h7, r[7:0]);
            chk("st", {3'h1, 1'b0, f, !f, r[1:0]}, st);
        end
        wr(3'h3, 8'h02);
        chk("st", 8'h07, st);
        wr(3'h3, 8'h00);
        chk("st", 8'h27, st);
        rd(3'h7, 8'h00);
        pin.door(1'b0);
        tick(6);
        rd(3'h7, 8'h80);
        rd(3'h1, 8'h04);
        wr(3'h3, 8'h01);
        pin.door(1'b1);
        tick(6);
        rd(3'h7, 8'h80);
        chk("st", 8'h67, st);
        pin.door(1'b0);
        tick(6);
        chk("st", 8'h27, st);
        read_active <= 1'b1;
        tick(3);
        chk("st", 8'h27, st);
        wr(3'h3, 8'h00);
        chk("st", 8'h67, st);
        read_active <= 1'b0;
        wr(3'h1, 8'h07);
        wr(3'h4, 8'h07);
        wr(3'h2, 8'h08);
        op_attention <= 1'b1;
        tick(1);
        op_attention <= 1'b0;
        tick(4);
        chk("st", 8'ha7, st);
        rd(3'h1, 8'h01);
        wr(3'h1, 8'h01);
        chk("st", 8'h27, st);
        pin.index_mark();
        tick(6);
        rd(3'h1, 8'h02);
        rd(3'h5, 8'h01);
        wr(3'h2, 8'h00);
        chk("st", 8'h27, st);
        wr(3'h2, 8'h08);
        chk("st", 8'ha7, st);
        wr(3'h4, 8'h00);
        chk("st", 8'h27, st);
        rd(3'h0, 8'h00);
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h01);
        finish_test;
    end
endmodule
